// [sim/pvu_src_model.sv]
// Behavioural model of the request sources wired to the priority unit.
`default_nettype none
module pvu_src_model (
  // Requests per source, bit 0 is the supply low-line warning.
  input  wire logic [25:0]       req,
  // Request pins of the unit.
  output var pvu_pkg::pvu_src_t  src_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // --------------------------------------------------------------------
  // Source wiring
  // --------------------------------------------------------------------
  // Sources are plain levels, so the unit's synchroniser sees real edges.
  always_comb begin
    src_out.parallel  = req[25:22];
    src_out.serial    = req[21:20];
    src_out.timer     = req[19:18];
    src_out.sysbus    = req[17:9];
    src_out.periph    = req[8:1];
    src_out.power_low = req[0];
  end
endmodule : pvu_src_model
`default_nettype wire

// [sim/pvu_top_bench.sv]
// Self-checking bench for the priority vector unit.
`default_nettype none
module pvu_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  // --------------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------------
  logic              pclk;
  logic              presetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [7:0]        paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic [25:0]       req;
  pvu_pkg::pvu_src_t src_in;
  logic              irq;
  pvu_pkg::pvu_vec_t vec_out;
  logic [31:0]       rd;
  logic              er;
  int                err_total;
  int                samples_checked;
  int                cycles;
  // One source of every group is routed to a level.
  int                route [8] = '{0, 1, 9, 18, 20, 22, 25, 17};

  pvu_top pvu_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .src_in(src_in),
    .irq(irq), .vec_out(vec_out));
  pvu_src_model pvu_src_model_i (.req(req), .src_out(src_in));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      stop_test();
    end
  end
  // --------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // The master holds the request until pready is sampled high, or for 20 cycles at most.
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    check("pready", {31'h0, pready}, 32'h1);
  endtask : apb

  task automatic drive(input logic [7:0] lv);
    logic [25:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) if (lv[i]) r[route[i]] = 1'b1;
    @(posedge pclk);
    req <= r;
  endtask : drive

  // Six cycles cover the four-edge path from source to irq.
  task automatic expect_vec(input logic ir, input logic [2:0] lv,
                            input logic [15:0] ad);
    repeat (6) @(posedge pclk);
    check("irq", {31'h0, irq}, {31'h0, ir});
    if (ir) check("vector", {12'h0, vec_out.valid, vec_out.level,
      vec_out.addr}, {12'h0, 1'b1, lv, ad});
  endtask : expect_vec

  // A dropped source needs its sync delay before ack, or it relatches.
  task automatic ack();
    repeat (4) @(posedge pclk);
    apb(1'b1, pvu_pkg::OFF_ACK, 32'h0);
  endtask : ack

  task automatic eoi();
    apb(1'b1, pvu_pkg::OFF_CMD_STAT, 32'h20);
  endtask : eoi
  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    req = '0;
    err_total = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, pvu_pkg::OFF_MASK_BASE, 32'h0);
    check("mask_rst", rd, {16'h0, pvu_pkg::BASE_RESET,
      pvu_pkg::MASK_RESET});
    apb(1'b0, pvu_pkg::OFF_ROUTE_LO, 32'h0);
    check("route_rst", rd, {4{3'h0, pvu_pkg::ROUTE_RESET}});
    apb(1'b1, 8'h14, 32'h0000_00ff);
    check("slverr_wr", {31'h0, er}, 32'h1);
    apb(1'b0, 8'h14, 32'h0);
    check("unmapped", rd, 32'h0);
    apb(1'b1, pvu_pkg::OFF_ROUTE_LO, 32'h1209_0100);
    apb(1'b1, pvu_pkg::OFF_ROUTE_HI, 32'h1119_1614);
    apb(1'b0, pvu_pkg::OFF_ROUTE_HI, 32'h0);
    check("route_hi", rd, 32'h1119_1614);
    apb(1'b1, pvu_pkg::OFF_MASK_BASE, 32'h08);
    drive(8'h28);
    expect_vec(1'b1, 3'd5, 16'd20);
    apb(1'b1, pvu_pkg::OFF_MASK_BASE, 32'h00);
    expect_vec(1'b1, 3'd3, 16'd12);
    apb(1'b0, pvu_pkg::OFF_ACK, 32'h0);
    check("vec_addr", rd, 32'h0000_000c);
    drive(8'h20);
    ack();
    expect_vec(1'b0, 3'd0, 16'd0);
    apb(1'b1, pvu_pkg::OFF_CMD_STAT, 32'h08);
    apb(1'b0, pvu_pkg::OFF_CMD_STAT, 32'h0);
    check("in_service", {24'h0, rd[7:0]}, 32'h08);
    drive(8'h22);
    expect_vec(1'b1, 3'd1, 16'd4);
    drive(8'h20);
    ack();
    eoi();
    expect_vec(1'b0, 3'd0, 16'd0);
    eoi();
    expect_vec(1'b1, 3'd5, 16'd20);
    drive(8'h00);
    ack();
    eoi();
    apb(1'b1, pvu_pkg::OFF_CMD_STAT, 32'(pvu_pkg::PVU_ROTATE));
    drive(8'h01);
    expect_vec(1'b1, 3'd0, 16'd0);
    drive(8'h00);
    ack();
    eoi();
    drive(8'h03);
    expect_vec(1'b1, 3'd1, 16'd4);
    drive(8'h00);
    ack();
    eoi();
    expect_vec(1'b1, 3'd0, 16'd0);
    ack();
    eoi();
    apb(1'b1, pvu_pkg::OFF_CMD_STAT, 32'h0000_0342);
    drive(8'h24);
    expect_vec(1'b1, 3'd5, 16'd20);
    apb(1'b1, pvu_pkg::OFF_CMD_STAT, 32'(pvu_pkg::PVU_NESTED));
    expect_vec(1'b1, 3'd2, 16'd8);
    drive(8'h00);
    ack();
    eoi();
    ack();
    eoi();
    apb(1'b1, pvu_pkg::OFF_CMD_STAT, 32'h90);
    apb(1'b1, pvu_pkg::OFF_MASK_BASE, 32'h0000_ab00);
    apb(1'b0, pvu_pkg::OFF_MASK_BASE, 32'h0);
    check("base", rd, 32'h0000_ab00);
    drive(8'h80);
    expect_vec(1'b1, 3'd7, 16'hab38);
    drive(8'h00);
    ack();
    eoi();
    apb(1'b1, pvu_pkg::OFF_CMD_STAT, 32'(pvu_pkg::PVU_POLLED));
    drive(8'h50);
    expect_vec(1'b0, 3'd0, 16'd0);
    apb(1'b0, pvu_pkg::OFF_CMD_STAT, 32'h0);
    check("poll", {24'h0, rd[7:0]}, 32'h84);
    apb(1'b1, pvu_pkg::OFF_CMD_STAT, 32'(pvu_pkg::PVU_NESTED));
    drive(8'h51);
    expect_vec(1'b1, 3'd0, 16'hab00);
    ack();
    expect_vec(1'b0, 3'd0, 16'd0);
    stop_test();
  end
endmodule : pvu_top_bench
`default_nettype wire

// [src/pvu_pkg.sv]
// Package with register map, field layouts and types of the priority unit.
`default_nettype none
package pvu_pkg;
  localparam int unsigned NUM_LEVELS   = 8;
  localparam int unsigned NUM_SOURCES  = 26;
  // Register word addresses on APB (byte addresses).
  localparam logic [7:0] OFF_CMD_STAT  = 8'h00;
  localparam logic [7:0] OFF_MASK_BASE = 8'h04;
  localparam logic [7:0] OFF_ROUTE_LO  = 8'h08;
  localparam logic [7:0] OFF_ROUTE_HI  = 8'h0c;
  localparam logic [7:0] OFF_ACK       = 8'h10;
  // Command byte fields.
  localparam int unsigned CMD_SEL_BIT  = 4;
  localparam int unsigned CMD_EOI_BIT  = 5;
  localparam int unsigned CMD_ISR_BIT  = 3;
  localparam int unsigned CMD_SPC_BIT  = 6;
  localparam int unsigned CMD_STEP_BIT = 7;
  localparam logic [1:0]  CMD_MODE_LO  = 2'h0;
  // Reset values.
  localparam logic [7:0]  MASK_RESET   = 8'hff;
  localparam logic [1:0]  MODE_RESET   = 2'h0;
  localparam logic [2:0]  LOW_RESET    = 3'h7;
  localparam logic [7:0]  BASE_RESET   = 8'h00;
  localparam logic [4:0]  ROUTE_RESET  = 5'h00;
  localparam logic [31:0] ROUTE_LO_RST = 32'h03020100;
  localparam logic [31:0] ROUTE_HI_RST = 32'h07060504;

  typedef enum logic [1:0] {
    PVU_NESTED  = 2'h0,
    PVU_ROTATE  = 2'h1,
    PVU_SPECIFIC = 2'h2,
    PVU_POLLED  = 2'h3
  } pvu_mode_t;

  typedef enum logic [1:0] {
    PVU_SEQ_CMD  = 2'b01,
    PVU_SEQ_BASE = 2'b10
  } pvu_seq_t;

  typedef struct packed {
    logic [3:0] parallel;
    logic [1:0] serial;
    logic [1:0] timer;
    logic [8:0] sysbus;
    logic [7:0] periph;
    logic       power_low;
  } pvu_src_t;

  typedef struct packed {
    logic        valid;
    logic [2:0]  level;
    logic [15:0] addr;
  } pvu_vec_t;
endpackage : pvu_pkg
`default_nettype wire

// [src/pvu_top.sv]
// Eight-level priority vector unit with APB register access.
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`default_nettype none
module pvu_top (
  // Clock and reset.
  input  wire logic            pclk,
  input  wire logic            presetn,
  // APB slave.
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [7:0]      paddr,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  // Request sources from pins.
  input  wire pvu_pkg::pvu_src_t src_in,
  // Processor side.
  output logic                 irq,
  output pvu_pkg::pvu_vec_t    vec_out
);
  localparam int unsigned NL = pvu_pkg::NUM_LEVELS;
  localparam int unsigned NS = pvu_pkg::NUM_SOURCES;
  // Every assertion below samples on pclk and sleeps while in reset.
  default clocking pvu_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ----------------------------------------------------------------------
  // Synchronisers and source routing
  // ----------------------------------------------------------------------
  logic [NS-1:0] src_meta_reg;
  logic [NS-1:0] src_sync_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_meta_reg <= '0;
      src_sync_reg <= '0;
    end else begin
      src_meta_reg <= src_in;
      src_sync_reg <= src_meta_reg;
    end
  end

  // Each level has a 5-bit source selector; value 31 and above 25 is off.
  logic [4:0] route_reg [NL];
  logic [NL-1:0] req_lvl;
  genvar gl;
  generate
    for (gl = 0; gl < NL; gl++) begin : g_route
      always_comb begin
        if (route_reg[gl] < 5'(NS))
          req_lvl[gl] = src_sync_reg[route_reg[gl]];
        else
          req_lvl[gl] = 1'b0;
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Control state
  // ----------------------------------------------------------------------
  logic [7:0]        mask_reg;
  pvu_pkg::pvu_mode_t mode_reg;
  logic [2:0]        low_reg;
  logic [7:0]        base_reg;
  logic              step8_reg;
  logic [7:0]        isr_reg;
  logic [7:0]        irr_reg;
  logic              rd_isr_reg;
  pvu_pkg::pvu_seq_t seq_reg;
  logic [2:0]        vec_lvl;

  logic wr_en;
  logic rd_en;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  logic hit_cmd;
  logic hit_mb;
  logic hit_ack;
  assign hit_cmd = paddr == pvu_pkg::OFF_CMD_STAT;
  assign hit_mb  = paddr == pvu_pkg::OFF_MASK_BASE;
  assign hit_ack = paddr == pvu_pkg::OFF_ACK;

  logic cmd_wr;
  logic eoi_wr;
  logic ack_wr;
  assign cmd_wr = wr_en && hit_cmd && !pwdata[pvu_pkg::CMD_EOI_BIT];
  assign eoi_wr = wr_en && hit_cmd && pwdata[pvu_pkg::CMD_EOI_BIT];
  assign ack_wr = wr_en && hit_ack;

  // Command word: bits 1:0 mode, bits 2..0 of the upper nibble reused.
  // Bit 4 set means the next write to the mask/base word sets the base.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg   <= pvu_pkg::pvu_mode_t'(pvu_pkg::MODE_RESET);
      low_reg    <= pvu_pkg::LOW_RESET;
      step8_reg  <= 1'b0;
      rd_isr_reg <= 1'b0;
    end else if (cmd_wr) begin
      mode_reg   <= pvu_pkg::pvu_mode_t'(pwdata[1:0]);
      rd_isr_reg <= pwdata[pvu_pkg::CMD_ISR_BIT];
      step8_reg  <= pwdata[pvu_pkg::CMD_STEP_BIT];
      if (pwdata[pvu_pkg::CMD_SPC_BIT])
        low_reg  <= pwdata[10:8];
    end else if (ack_wr && mode_reg == pvu_pkg::PVU_ROTATE) begin
      low_reg <= vec_lvl;
    end
  end

  // Access order on the shared word: after a command with the select bit,
  // the next write goes to the base, every other write to the mask.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_reg  <= pvu_pkg::PVU_SEQ_CMD;
      mask_reg <= pvu_pkg::MASK_RESET;
      base_reg <= pvu_pkg::BASE_RESET;
    end else if (cmd_wr && pwdata[pvu_pkg::CMD_SEL_BIT]) begin
      seq_reg <= pvu_pkg::PVU_SEQ_BASE;
    end else if (wr_en && hit_mb) begin
      case (seq_reg)
        pvu_pkg::PVU_SEQ_BASE: begin
          base_reg <= pwdata[15:8];
          seq_reg  <= pvu_pkg::PVU_SEQ_CMD;
        end
        pvu_pkg::PVU_SEQ_CMD: begin
          mask_reg <= pwdata[7:0];
        end
        default: begin
          seq_reg <= pvu_pkg::PVU_SEQ_CMD;
        end
      endcase
    end
  end

  integer ri;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (ri = 0; ri < NL; ri++) route_reg[ri] <= pvu_pkg::ROUTE_RESET;
    end else if (wr_en && (paddr == pvu_pkg::OFF_ROUTE_LO)) begin
      for (ri = 0; ri < 4; ri++) route_reg[ri] <= pwdata[ri*8 +: 5];
    end else if (wr_en && (paddr == pvu_pkg::OFF_ROUTE_HI)) begin
      for (ri = 0; ri < 4; ri++) route_reg[ri+4] <= pwdata[ri*8 +: 5];
    end
  end

  // ----------------------------------------------------------------------
  // Priority resolution
  // ----------------------------------------------------------------------
  // Requests are latched so that a short pulse is not lost; a level
  // leaves the request register when it is acknowledged.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irr_reg <= '0;
    end else begin
      for (int i = 0; i < NL; i++) begin
        if (req_lvl[i])
          irr_reg[i] <= 1'b1; // new request wins over ack clear
        else if (ack_wr && vec_lvl == 3'(i))
          irr_reg[i] <= 1'b0;
      end
    end
  end

  // Lowest level in the ring: 7 in nested mode, low_reg otherwise.
  logic [2:0] low_eff;
  assign low_eff = (mode_reg == pvu_pkg::PVU_NESTED) ? 3'h7 : low_reg;

  logic [7:0] pend;
  assign pend = irr_reg & ~mask_reg;

  // Rank 0 is highest; a level's rank is its distance after low_eff, less one.
  function automatic logic [2:0] rank_of(input logic [2:0] lvl,
                                         input logic [2:0] low);
    rank_of = lvl - low - 3'h1;
  endfunction : rank_of

  logic       req_any;
  logic [2:0] req_best;
  logic       isr_any;
  logic [2:0] isr_best;
  always_comb begin
    req_any  = 1'b0;
    req_best = 3'h0;
    isr_any  = 1'b0;
    isr_best = 3'h0;
    for (int k = NL - 1; k >= 0; k--) begin
      if (pend[3'(k) + low_eff + 3'h1]) begin
        req_any  = 1'b1;
        req_best = 3'(k) + low_eff + 3'h1;
      end
      if (isr_reg[3'(k) + low_eff + 3'h1]) begin
        isr_any  = 1'b1;
        isr_best = 3'(k) + low_eff + 3'h1;
      end
    end
  end

  logic win;
  assign win = req_any && (!isr_any ||
               rank_of(req_best, low_eff) < rank_of(isr_best, low_eff));

  assign vec_lvl = vec_out.level;

  // In-service bits: acknowledge sets, end command clears the highest.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      isr_reg <= '0;
    end else begin
      for (int i = 0; i < NL; i++) begin
        if (ack_wr && vec_out.valid && vec_lvl == 3'(i))
          isr_reg[i] <= 1'b1;
        else if (eoi_wr && isr_any && isr_best == 3'(i))
          isr_reg[i] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt and vector outputs
  // ----------------------------------------------------------------------
  logic [15:0] vec_addr;
  always_comb begin
    if (step8_reg)
      vec_addr = {base_reg[7:6], 14'h0} | 16'({base_reg[5:0], 8'h0})
                 | 16'({req_best, 3'h0});
    else
      vec_addr = {base_reg, 8'h0} | 16'({req_best, 2'h0});
  end

  logic [15:0] vec_base;
  assign vec_base = step8_reg ? (vec_addr & 16'hffc0) : (vec_addr & 16'hffe0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq     <= 1'b0;
      vec_out <= '0;
    end else begin
      irq           <= win && (mode_reg != pvu_pkg::PVU_POLLED);
      vec_out.valid <= win;
      vec_out.level <= req_best;
      vec_out.addr  <= step8_reg ? (vec_base | 16'({req_best, 3'h0}))
                                 : (vec_base | 16'({req_best, 2'h0}));
    end
  end

  // ----------------------------------------------------------------------
  // APB read path
  // ----------------------------------------------------------------------
  logic [7:0] stat_byte;
  assign stat_byte = {win, 4'h0, req_best};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable &&
                 !(paddr == pvu_pkg::OFF_CMD_STAT ||
                   paddr == pvu_pkg::OFF_MASK_BASE ||
                   paddr == pvu_pkg::OFF_ROUTE_LO ||
                   paddr == pvu_pkg::OFF_ROUTE_HI ||
                   paddr == pvu_pkg::OFF_ACK);
      prdata  <= '0;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          pvu_pkg::OFF_CMD_STAT: begin
            if (mode_reg == pvu_pkg::PVU_POLLED)
              prdata <= {24'h0, stat_byte};
            else if (rd_isr_reg)
              prdata <= {24'h0, isr_reg};
            else
              prdata <= {24'h0, irr_reg};
          end
          pvu_pkg::OFF_MASK_BASE: prdata <= {16'h0, base_reg, mask_reg};
          pvu_pkg::OFF_ACK:       prdata <= {16'h0, vec_out.addr};
          pvu_pkg::OFF_ROUTE_LO: begin
            prdata <= {3'h0, route_reg[3], 3'h0, route_reg[2],
                       3'h0, route_reg[1], 3'h0, route_reg[0]};
          end
          pvu_pkg::OFF_ROUTE_HI: begin
            prdata <= {3'h0, route_reg[7], 3'h0, route_reg[6],
                       3'h0, route_reg[5], 3'h0, route_reg[4]};
          end
          default: prdata <= '0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  // The ack, end-command and base-write triggers are spelled out as named sequences.
  sequence s_ack;
    ack_wr && vec_out.valid;
  endsequence

  sequence s_eoi;
    eoi_wr && isr_any;
  endsequence

  sequence s_base_wr;
    seq_reg == pvu_pkg::PVU_SEQ_BASE && wr_en && hit_mb;
  endsequence

  AST_IRQ_NEEDS_WIN: assert property (
    irq |-> $past(win))
    else $error("irq without winning request");
  AST_MASKED_QUIET: assert property (
    (mask_reg == 8'hff) [*2] |-> !irq)
    else $error("irq while masked");
  AST_ACK_SETS_ISR: assert property (
    s_ack |=> isr_reg[$past(vec_lvl)])
    else $error("ack missed");
  AST_POLLED_NO_IRQ: assert property (
    $past(mode_reg) == pvu_pkg::PVU_POLLED |-> !irq)
    else $error("irq in polled mode");
  AST_NESTED_ORDER: assert property (
    (mode_reg == pvu_pkg::PVU_NESTED && pend[0]) |=> vec_out.level == 3'h0)
    else $error("level 0 not preferred");
  AST_ROTATE_LOW: assert property (
    (s_ack and (mode_reg == pvu_pkg::PVU_ROTATE) and !cmd_wr)
    |=> low_reg == $past(vec_lvl))
    else $error("no rotate");
  // The vector was built with last cycle's step, which software may change.
  AST_SPACING: assert property (
    vec_out.valid |-> ($past(step8_reg) ? vec_out.addr[2:0] == 3'h0
                                        : vec_out.addr[1:0] == 2'h0))
    else $error("vector spacing wrong");
  AST_BASE_SEQ: assert property (
    s_base_wr |=> seq_reg == pvu_pkg::PVU_SEQ_CMD &&
                  mask_reg == $past(mask_reg))
    else $error("base write order broken");
  AST_BASE_LOADS: assert property (
    s_base_wr |=> base_reg == $past(pwdata[15:8]))
    else $error("base not loaded");
  AST_EOI_CLEARS: assert property (
    s_eoi |=> !isr_reg[$past(isr_best)])
    else $error("end command left level in service");
  AST_LEVEL0_BLOCKS: assert property (
    (mode_reg == pvu_pkg::PVU_NESTED && isr_reg[0]) |=> !irq)
    else $error("irq while top level in service");
  AST_MASK_HONOURED: assert property (
    vec_out.valid |-> !$past(mask_reg[req_best]))
    else $error("masked level won");
  AST_SPECIFIC_LOW: assert property (
    (cmd_wr && pwdata[pvu_pkg::CMD_SPC_BIT])
    |=> low_reg == $past(pwdata[10:8]))
    else $error("lowest level not loaded");
  AST_VEC_IN_TABLE: assert property (
    vec_out.valid |-> vec_out.addr[15:8] == $past(base_reg))
    else $error("vector outside its table");
  AST_IRQ_HAS_VECTOR: assert property (
    irq |-> vec_out.valid)
    else $error("irq without vector");
  AST_PREADY_PULSE: assert property (
    pready |=> !pready)
    else $error("pready held past one cycle");
  AST_SLVERR_WITH_READY: assert property (
    pslverr |-> pready)
    else $error("pslverr without pready");
endmodule : pvu_top
`default_nettype wire
